// *** core/sar_adc_defines.vh ***
/*
 Constants of the SAR converter control and result block: register byte
 offsets, field positions, reset values and timing counts.
 Assumes a 10 MHz aclk and 32-bit AXI4-Lite data with one register per word.
*/
// Contract
// R1: Ten-bit result, nine analog input channels.
// R2: Repeatedly convert one selected source.
// R3: Done interrupt once per completed conversion.
// R4: Unselected analog pins stay port pins.
// R5: Input one shared with amplifier outputs.
// R6: Hold sampled voltage during whole conversion.
// R7: Run bit 7 enables comparison generator.
// R8: Enable bit 0 enables comparator.
// R9: Resolve one bit per step, MSB first.
// R10: After LSB, copy result into registers.
// R11: Word result low ten bits, upper zero.
// R12: Low byte holds lower eight bits.
// R13: High byte holds upper eight bits.
// R14: Per-timer word result for timer triggers.
// R15: Per-timer low byte for timer triggers.
// R16: Result reads insert one wait cycle.
// R17: Run without comparator is prohibited.
// R18: One microsecond from comparator to run.
// R19: Results hold until next; writes ignored.
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH

`define OFS_MODE       8'h00
`define OFS_CHAN       8'h04
`define OFS_TRIG       8'h08
`define OFS_STATUS     8'h0C
`define OFS_RES_WORD   8'h10
`define OFS_RES_LOW    8'h14
`define OFS_RES_HIGH   8'h18
`define OFS_T0_WORD    8'h1C
`define OFS_T0_LOW     8'h20
`define OFS_T1_WORD    8'h24
`define OFS_T1_LOW     8'h28
`define OFS_IRQ_STAT   8'h2C
`define OFS_IRQ_MASK   8'h30

`define MODE_RUN_BIT   7
`define MODE_CMP_BIT   0
`define MODE_RSV_BIT   6

`define CHAN_OPAMP     4'h9
`define CHAN_GAINAMP   4'hA
`define CHAN_VREF      4'hB
`define CHAN_SHARED    1

`define IRQ_DONE_BIT   0
`define IRQ_T0_BIT     1
`define IRQ_T1_BIT     2

`define RST_MODE       8'h00
`define RST_CHAN       4'h0
`define RST_RES        10'h000

`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`define CLK_PERIOD_NS  100
`define SETTLE_NS      1000
`define SETTLE_CYC     ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAMPLE_CYC     8
`define STEP_CYC       4

`endif

// *** core/sar_adc_result_control.v ***
/*
 SAR converter control: mode and channel registers, the approximation
 sequencer, word and byte result registers, timer-synchronised results,
 interrupt status and mask, all behind an AXI4-Lite slave.
 Assumes the comparator decision arrives asynchronously from the analog
 macro and timer triggers are one-cycle pulses on aclk.
*/
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`include "sar_adc_defines.vh"

module sar_adc_result_control #(
	parameter SAMPLE_CYC = `SAMPLE_CYC,
	parameter STEP_CYC   = `STEP_CYC,
	parameter SETTLE_CYC = `SETTLE_CYC
)(
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        comp_in,
	input  wire [1:0]  timer_trig,
	output wire        vgen_en,
	output wire        comp_en,
	output wire [3:0]  src_sel,
	output wire        sample_en,
	output wire        hold_en,
	output wire [9:0]  sar_code,
	output wire [8:0]  ain_analog_sel,
	output wire [8:0]  ain_port_en,
	output wire        conversion_done_irq,
	output wire        irq
);

localparam ST_IDLE   = 2'd0;
localparam ST_SAMPLE = 2'd1;
localparam ST_STEP   = 2'd2;

function addr_known;
	input [7:0] a;
	begin
		addr_known = (a[1:0] == 2'b00) && (a <= `OFS_IRQ_MASK);
	end
endfunction

function addr_is_result;
	input [7:0] a;
	begin
		addr_is_result = (a >= `OFS_RES_WORD) && (a <= `OFS_T1_LOW);
	end
endfunction

reg        comp_meta_r;
reg        comp_sync_r;
reg        run_r;
reg        cmp_r;
reg  [4:0] fr_r;
reg  [3:0] chan_r;
reg        trig_mode_r;
reg  [2:0] irq_stat_r;
reg  [2:0] irq_mask_r;
reg  [7:0] settle_cnt_r;
reg        unsettled_r;
reg        first_r;
reg  [1:0] state_r;
reg  [7:0] cnt_r;
reg  [9:0] sar_r;
reg  [9:0] bit_r;
reg  [1:0] tag_r;
reg  [1:0] last_tag_r;
reg  [9:0] res_word_r;
reg  [9:0] tres_r [0:1];
reg        done_r;
reg        aw_hold_r;
reg  [7:0] awaddr_r;
reg        w_hold_r;
reg  [31:0] wdata_r;
reg        wstrb0_r;
reg        bvalid_r;
reg  [1:0] bresp_r;
reg        rd_busy_r;
reg  [7:0] araddr_r;
reg        rd_wait_r;
reg        rvalid_r;
reg  [31:0] rdata_r;
reg  [1:0] rresp_r;
reg  [31:0] rd_nxt;
reg  [9:0] sar_nxt;
reg  [2:0] irq_set;
reg  [2:0] irq_clr;
reg  [8:0] sel_nxt;

wire       wr_fire;
wire       wr_lane;
wire       conv_ok;
wire       settled;
wire       step_end;
wire       start_req;
integer    i;

assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
assign wr_lane = wr_fire && wstrb0_r;
// R17: prohibited combo
assign conv_ok = run_r && cmp_r;
assign settled = (settle_cnt_r == SETTLE_CYC[7:0]);
assign step_end = (cnt_r == STEP_CYC[7:0] - 8'd1);
// R2: continuous or timer start
assign start_req = conv_ok && (!trig_mode_r || (|timer_trig));

// Comparator decision crosses from the analog macro
always @(posedge aclk) begin
	if (!aresetn) begin
		comp_meta_r <= 1'b0;
		comp_sync_r <= 1'b0;
	end else begin
		comp_meta_r <= comp_in;
		comp_sync_r <= comp_meta_r;
	end
end

// Control registers
always @(posedge aclk) begin
	if (!aresetn) begin
		run_r       <= 1'b0;
		cmp_r       <= 1'b0;
		fr_r        <= 5'h00;
		chan_r      <= `RST_CHAN;
		trig_mode_r <= 1'b0;
		irq_mask_r  <= 3'h0;
	end else if (wr_lane) begin
		case (awaddr_r)
			`OFS_MODE: begin
				// R7: generator run bit
				run_r <= wdata_r[`MODE_RUN_BIT];
				// R8: comparator enable bit
				cmp_r <= wdata_r[`MODE_CMP_BIT];
				fr_r  <= wdata_r[5:1];
			end
			`OFS_CHAN: begin
				chan_r <= wdata_r[3:0];
			end
			`OFS_TRIG: begin
				trig_mode_r <= wdata_r[0];
			end
			`OFS_IRQ_MASK: begin
				irq_mask_r <= wdata_r[2:0];
			end
			default: begin
			end
		endcase
	end
end

// R18: comparator settling time
always @(posedge aclk) begin
	if (!aresetn) begin
		settle_cnt_r <= 8'h00;
	end else if (!cmp_r) begin
		settle_cnt_r <= 8'h00;
	end else if (!settled) begin
		settle_cnt_r <= settle_cnt_r + 8'd1;
	end
end

// Sequencer
always @(posedge aclk) begin
	if (!aresetn) begin
		state_r     <= ST_IDLE;
		cnt_r       <= 8'h00;
		sar_r       <= `RST_RES;
		bit_r       <= 10'h000;
		tag_r       <= 2'b00;
		last_tag_r  <= 2'b00;
		res_word_r  <= `RST_RES;
		tres_r[0]   <= `RST_RES;
		tres_r[1]   <= `RST_RES;
		done_r      <= 1'b0;
		first_r     <= 1'b0;
		unsettled_r <= 1'b0;
	end else begin
		done_r <= 1'b0;
		if (!run_r) begin
			first_r <= 1'b1;
		end
		case (state_r)
			ST_IDLE: begin
				if (start_req) begin
					state_r <= ST_SAMPLE;
					cnt_r   <= 8'h00;
					// Timer 0 wins when both fire together
					tag_r   <= !trig_mode_r ? 2'b00 :
						(timer_trig[0] ? 2'b01 : 2'b10);
					if (first_r) begin
						unsettled_r <= !settled;
					end
					first_r <= 1'b0;
				end
			end
			ST_SAMPLE: begin
				if (!conv_ok) begin
					state_r <= ST_IDLE;
				end else if (cnt_r == SAMPLE_CYC[7:0] - 8'd1) begin
					state_r <= ST_STEP;
					cnt_r   <= 8'h00;
					// R9: start at the MSB
					bit_r   <= 10'h200;
					sar_r   <= 10'h200;
				end else begin
					cnt_r <= cnt_r + 8'd1;
				end
			end
			ST_STEP: begin
				if (!conv_ok) begin
					state_r <= ST_IDLE;
				end else if (step_end) begin
					cnt_r <= 8'h00;
					// R9: one decision per step
					sar_r <= sar_nxt | (bit_r >> 1);
					bit_r <= bit_r >> 1;
					if (bit_r[0]) begin
						// R10: LSB done, store result
						sar_r   <= sar_nxt;
						done_r  <= 1'b1;
						state_r <= start_req ? ST_SAMPLE : ST_IDLE;
						// R12: low byte follows word
						res_word_r <= sar_nxt;
						// R14: per-timer word
						for (i = 0; i < 2; i = i + 1) begin
							if (tag_r[i]) begin
								tres_r[i] <= sar_nxt;
							end
						end
						last_tag_r <= tag_r;
						tag_r <= !trig_mode_r ? 2'b00 :
							(timer_trig[0] ? 2'b01 :
							(timer_trig[1] ? 2'b10 : 2'b00));
					end
				end else begin
					cnt_r <= cnt_r + 8'd1;
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
		endcase
	end
end

// Comparator low means trial above input, so drop the bit
always @* begin
	sar_nxt = comp_sync_r ? sar_r : (sar_r & ~bit_r);
end

// Interrupt status, set beats a same-cycle clear
always @* begin
	irq_set = 3'h0;
	irq_set[`IRQ_DONE_BIT] = done_r;
	irq_set[`IRQ_T0_BIT] = done_r && last_tag_r[0];
	irq_set[`IRQ_T1_BIT] = done_r && last_tag_r[1];
	irq_clr = 3'h0;
	if (wr_lane && (awaddr_r == `OFS_IRQ_STAT)) begin
		irq_clr = wdata_r[2:0];
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		irq_stat_r <= 3'h0;
	end else begin
		irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
	end
end

// R3: one pulse per conversion
assign conversion_done_irq = done_r;
assign irq = |(irq_stat_r & irq_mask_r);

// AXI write channels, taken in either order
always @(posedge aclk) begin
	if (!aresetn) begin
		aw_hold_r <= 1'b0;
		awaddr_r  <= 8'h00;
		w_hold_r  <= 1'b0;
		wdata_r   <= 32'h0000_0000;
		wstrb0_r  <= 1'b0;
		bvalid_r  <= 1'b0;
		bresp_r   <= `RESP_OKAY;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_r <= 1'b1;
			wdata_r  <= s_axi_wdata;
			wstrb0_r <= s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			bvalid_r  <= 1'b1;
			// R19: result writes are dropped
			bresp_r   <= addr_known(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end
end

assign s_axi_awready = !aw_hold_r && !bvalid_r;
assign s_axi_wready  = !w_hold_r && !bvalid_r;
assign s_axi_bvalid  = bvalid_r;
assign s_axi_bresp   = bresp_r;

// Read data selection
always @* begin
	rd_nxt = 32'h0000_0000;
	case (araddr_r)
		`OFS_MODE: begin
			rd_nxt[`MODE_RUN_BIT] = run_r;
			rd_nxt[5:1] = fr_r;
			rd_nxt[`MODE_CMP_BIT] = cmp_r;
		end
		`OFS_CHAN: begin
			rd_nxt[3:0] = chan_r;
		end
		`OFS_TRIG: begin
			rd_nxt[0] = trig_mode_r;
		end
		`OFS_STATUS: begin
			rd_nxt[0] = (state_r != ST_IDLE);
			rd_nxt[1] = run_r && !cmp_r;
			rd_nxt[2] = settled;
			rd_nxt[3] = unsettled_r;
			rd_nxt[5:4] = last_tag_r;
		end
		// R11: upper bits read zero
		`OFS_RES_WORD: begin
			rd_nxt[9:0] = res_word_r;
		end
		// R12: lower eight bits
		`OFS_RES_LOW: begin
			rd_nxt[7:0] = res_word_r[7:0];
		end
		// R13: upper eight bits
		`OFS_RES_HIGH: begin
			rd_nxt[7:0] = res_word_r[9:2];
		end
		`OFS_T0_WORD: begin
			rd_nxt[9:0] = tres_r[0];
		end
		// R15: per-timer low byte
		`OFS_T0_LOW: begin
			rd_nxt[7:0] = tres_r[0][7:0];
		end
		`OFS_T1_WORD: begin
			rd_nxt[9:0] = tres_r[1];
		end
		`OFS_T1_LOW: begin
			rd_nxt[7:0] = tres_r[1][7:0];
		end
		`OFS_IRQ_STAT: begin
			rd_nxt[2:0] = irq_stat_r;
		end
		`OFS_IRQ_MASK: begin
			rd_nxt[2:0] = irq_mask_r;
		end
		default: begin
			rd_nxt = 32'h0000_0000;
		end
	endcase
end

// AXI read channel
always @(posedge aclk) begin
	if (!aresetn) begin
		rd_busy_r <= 1'b0;
		araddr_r  <= 8'h00;
		rd_wait_r <= 1'b0;
		rvalid_r  <= 1'b0;
		rdata_r   <= 32'h0000_0000;
		rresp_r   <= `RESP_OKAY;
	end else begin
		if (s_axi_arvalid && s_axi_arready) begin
			rd_busy_r <= 1'b1;
			araddr_r  <= s_axi_araddr;
			// R16: result read wait cycle
			rd_wait_r <= addr_is_result(s_axi_araddr);
		end else if (rd_busy_r && !rvalid_r) begin
			if (rd_wait_r) begin
				rd_wait_r <= 1'b0;
			end else begin
				rvalid_r <= 1'b1;
				rdata_r  <= rd_nxt;
				rresp_r  <= addr_known(araddr_r) ? `RESP_OKAY : `RESP_SLVERR;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r  <= 1'b0;
			rd_busy_r <= 1'b0;
		end
	end
end

assign s_axi_arready = !rd_busy_r;
assign s_axi_rvalid  = rvalid_r;
assign s_axi_rdata   = rdata_r;
assign s_axi_rresp   = rresp_r;

// R4: only the selected pin leaves port use
always @* begin
	sel_nxt = 9'h000;
	if (cmp_r) begin
		if (chan_r <= 4'd8) begin
			sel_nxt[chan_r] = 1'b1;
		end
		// R5: amplifier shares input one
		if ((chan_r == `CHAN_OPAMP) || (chan_r == `CHAN_GAINAMP)) begin
			sel_nxt[`CHAN_SHARED] = 1'b1;
		end
	end
end

// R1: nine channels, ten-bit code
assign ain_analog_sel = sel_nxt;
assign ain_port_en    = ~sel_nxt;
assign src_sel        = chan_r;
assign vgen_en        = run_r;
assign comp_en        = cmp_r;
assign sample_en      = (state_r == ST_SAMPLE);
// R6: hold over every step
assign hold_en        = (state_r == ST_STEP);
assign sar_code       = sar_r;

endmodule // sar_adc_result_control

// *** tb/sar_adc_result_control_monitor.sv ***
/*
 Port checker of the SAR converter control block.
 Assumes one aclk domain and synchronous active-low aresetn.
*/
`include "sar_adc_defines.vh"
module sar_adc_result_control_monitor (
	input logic       aclk,
	input logic       aresetn,
	input logic [7:0] s_axi_araddr,
	input logic       s_axi_arvalid,
	input logic       s_axi_arready,
	input logic       s_axi_rvalid,
	input logic       s_axi_bvalid,
	input logic       comp_en,
	input logic       vgen_en,
	input logic       sample_en,
	input logic       hold_en,
	input logic [9:0] sar_code,
	input logic [8:0] ain_analog_sel,
	input logic [8:0] ain_port_en,
	input logic       conversion_done_irq,
	input logic       irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_rst;
		$rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs busy after reset");
	property p_pulse;
		conversion_done_irq |=> !conversion_done_irq;
	endproperty
	a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
	property p_port;
		ain_port_en == ~ain_analog_sel;
	endproperty
	a_port: assert property (p_port) else $error("port enable not inverse of select");
	property p_onehot;
		$onehot0(ain_analog_sel);
	endproperty
	a_onehot: assert property (p_onehot) else $error("more than one pin selected");
	property p_hold;
		hold_en |-> !sample_en ##1 (hold_en || conversion_done_irq || !$past(comp_en && vgen_en));
	endproperty
	a_hold: assert property (p_hold) else $error("sampling while held");
	property p_nocmp;
		!(comp_en && vgen_en) ##1 !(comp_en && vgen_en) |-> !sample_en && !hold_en;
	endproperty
	a_nocmp: assert property (p_nocmp) else $error("converting while not enabled");
	property p_msb;
		$rose(hold_en) |-> ##[0:1] sar_code == 10'h200;
	endproperty
	a_msb: assert property (p_msb) else $error("first trial not msb");
	property p_done;
		$fell(hold_en) && comp_en && vgen_en |-> ##[0:2] conversion_done_irq;
	endproperty
	a_done: assert property (p_done) else $error("no done after last step");
	// Result reads are 8'h10 to 8'h28, aligned
	property p_wait;
		s_axi_arvalid && s_axi_arready && s_axi_araddr >= `OFS_RES_WORD && s_axi_araddr <= `OFS_T1_LOW
		&& s_axi_araddr[1:0] == 2'b00 |=> !s_axi_rvalid ##1 !s_axi_rvalid ##1 s_axi_rvalid;
	endproperty
	a_wait: assert property (p_wait) else $error("result read without wait cycle");
endmodule // sar_adc_result_control_monitor

bind sar_adc_result_control sar_adc_result_control_monitor u_mon (.aclk, .aresetn, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .comp_en, .vgen_en, .sample_en,
	.hold_en, .sar_code, .ain_analog_sel, .ain_port_en, .conversion_done_irq, .irq);

// *** tb/testbench.sv ***
/*
 Self-checking bench: registers over AXI4-Lite, conversions, timer results, interrupts.
 Assumes the design header on the include path and a 10 MHz aclk.
*/
`include "sar_adc_defines.vh"
`define CHK(n,e,g) begin n_compared++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk, aresetn, comp_in;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, src_sel;
	logic [1:0]  s_axi_bresp, s_axi_rresp, timer_trig;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        vgen_en, comp_en, sample_en, hold_en, conversion_done_irq, irq;
	logic [9:0]  sar_code, vin;
	logic [8:0]  ain_analog_sel, ain_port_en;
	int          errors, n_compared;

	sar_adc_result_control u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .comp_in, .timer_trig, .vgen_en, .comp_en, .src_sel, .sample_en,
		.hold_en, .sar_code, .ain_analog_sel, .ain_port_en, .conversion_done_irq, .irq);

	initial begin
		aclk = 0;
		forever #50 aclk = ~aclk;
	end

	// Ideal analog input: high while input not below trial
	always @(posedge aclk) comp_in <= (vin >= sar_code);

	task test_done;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task tmo;
		errors++;
		$display("[ERR] wait exp 1 got 0");
		test_done();
	endtask

	task wr(input [7:0] a, input [31:0] d, input [1:0] er);
		int i;
		bit fa, fw, fb;
		{fa, fw, fb} = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		for (i = 0; i < 50 && !fb; i++) begin
			@(posedge aclk);
			if (s_axi_awready && !fa) begin
				fa = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wready && !fw) begin
				fw = 1;
				s_axi_wvalid <= 0;
			end
			if (s_axi_bvalid) begin
				fb = 1;
				s_axi_bready <= 0;
				`CHK("bresp", er, s_axi_bresp)
			end
		end
		if (!fb) tmo();
		// Gap so the next call never re-raises in one step
		@(posedge aclk);
	endtask

	task rd(input [7:0] a, input [31:0] ex, input [1:0] er, input string n);
		int i;
		bit fa, fr;
		{fa, fr} = 0;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		for (i = 0; i < 50 && !fr; i++) begin
			@(posedge aclk);
			if (s_axi_arready && !fa) begin
				fa = 1;
				s_axi_arvalid <= 0;
			end
			if (s_axi_rvalid) begin
				fr = 1;
				s_axi_rready <= 0;
				`CHK(n, ex, s_axi_rdata)
				`CHK("rresp", er, s_axi_rresp)
			end
		end
		if (!fr) tmo();
		@(posedge aclk);
	endtask

	task wait_done;
		int i;
		for (i = 0; i < 300 && conversion_done_irq !== 1'b1; i++) @(posedge aclk);
		if (conversion_done_irq !== 1'b1) tmo();
		repeat (3) @(posedge aclk);
	endtask

	task t_reset;
		rd(`OFS_MODE, 0, `RESP_OKAY, "mode");
		rd(`OFS_RES_WORD, 0, `RESP_OKAY, "word");
		`CHK("port_en", 9'h1FF, ain_port_en)
	endtask

	task t_conv;
		vin <= 10'h2D6;
		wr(`OFS_CHAN, 3, `RESP_OKAY);
		wr(`OFS_IRQ_MASK, 1, `RESP_OKAY);
		wr(`OFS_MODE, 8'h01, `RESP_OKAY);
		`CHK("cmp", 1'b1, comp_en)
		`CHK("vgen", 1'b0, vgen_en)
		`CHK("sel", 9'h008, ain_analog_sel)
		`CHK("src", 4'h3, src_sel)
		wr(`OFS_CHAN, 9, `RESP_OKAY);
		`CHK("sel_amp", 9'h002, ain_analog_sel)
		wr(`OFS_CHAN, 10, `RESP_OKAY);
		`CHK("sel_pga", 9'h002, ain_analog_sel)
		wr(`OFS_CHAN, 11, `RESP_OKAY);
		`CHK("sel_ref", 9'h000, ain_analog_sel)
		`CHK("src_ref", 4'hB, src_sel)
		wr(`OFS_CHAN, 3, `RESP_OKAY);
		repeat (10) @(posedge aclk);
		wr(`OFS_MODE, 8'h81, `RESP_OKAY);
		`CHK("vgen", 1'b1, vgen_en)
		wait_done();
		`CHK("irq", 1'b1, irq)
		rd(`OFS_RES_WORD, {22'h0, vin}, `RESP_OKAY, "word");
		rd(`OFS_RES_LOW, vin[7:0], `RESP_OKAY, "low");
		rd(`OFS_RES_HIGH, vin[9:2], `RESP_OKAY, "high");
		wait_done();
		rd(`OFS_RES_WORD, {22'h0, vin}, `RESP_OKAY, "again");
		wr(`OFS_MODE, 0, `RESP_OKAY);
		wr(`OFS_RES_WORD, 32'hFFFF_FFFF, `RESP_OKAY);
		rd(`OFS_RES_WORD, {22'h0, vin}, `RESP_OKAY, "ro");
		repeat (4) @(posedge aclk);
		wr(`OFS_IRQ_STAT, 7, `RESP_OKAY);
		rd(`OFS_IRQ_STAT, 0, `RESP_OKAY, "stat");
		`CHK("irq", 1'b0, irq)
	endtask

	// Timer n starts a conversion; values differ so stale results show
	task t_timer;
		int n;
		wr(`OFS_TRIG, 1, `RESP_OKAY);
		wr(`OFS_MODE, 8'h01, `RESP_OKAY);
		repeat (10) @(posedge aclk);
		wr(`OFS_MODE, 8'h81, `RESP_OKAY);
		for (n = 0; n < 2; n++) begin
			vin <= n ? 10'h155 : 10'h3A1;
			repeat (20) @(posedge aclk);
			`CHK("idle", 1'b0, hold_en)
			timer_trig <= 2'b01 << n;
			@(posedge aclk);
			timer_trig <= 2'b00;
			wait_done();
			rd(n ? `OFS_T1_WORD : `OFS_T0_WORD, {22'h0, vin}, `RESP_OKAY, "tword");
			rd(n ? `OFS_T1_LOW : `OFS_T0_LOW, vin[7:0], `RESP_OKAY, "tlow");
			rd(`OFS_RES_WORD, {22'h0, vin}, `RESP_OKAY, "word");
			rd(`OFS_IRQ_STAT, n ? 5 : 3, `RESP_OKAY, "stat");
			wr(`OFS_IRQ_STAT, 7, `RESP_OKAY);
		end
		rd(`OFS_T0_WORD, 32'h0000_03A1, `RESP_OKAY, "t0held");
	endtask

	task t_bad;
		wr(`OFS_MODE, 8'h80, `RESP_OKAY);
		// Continuous mode, so only the missing comparator stops it
		wr(`OFS_TRIG, 0, `RESP_OKAY);
		repeat (80) @(posedge aclk);
		`CHK("noconv", 1'b0, sample_en | hold_en)
		rd(`OFS_STATUS, 32'h0000_0022, `RESP_OKAY, "status");
		rd(`OFS_MODE, 32'h0000_0080, `RESP_OKAY, "mode");
		wr(8'h34, 1, `RESP_SLVERR);
		rd(8'h34, 0, `RESP_SLVERR, "unmapped");
		wr(`OFS_MODE, 0, `RESP_OKAY);
	endtask

	initial begin
		aresetn = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, timer_trig, vin} = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		s_axi_wstrb = 4'hF;
		errors = 0;
		n_compared = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_reset();
		t_conv();
		t_timer();
		t_bad();
		test_done();
	end
endmodule // testbench
